// [od_slice_pkg.sv]
package od_slice_pkg;

  // Object dictionary indices.
  localparam logic [15:0] IDX_FREQ_MAP      = 16'h1A03;
  localparam logic [15:0] IDX_STAMP_MAP     = 16'h1A04;
  localparam logic [15:0] IDX_SHORT_MAP     = 16'h1A05;
  localparam logic [15:0] IDX_CHANNEL_TYPE  = 16'h1C00;
  localparam logic [15:0] IDX_OUT_ASSIGN    = 16'h1C12;
  localparam logic [15:0] IDX_IN_ASSIGN     = 16'h1C13;
  localparam logic [15:0] IDX_OUT_SYNC      = 16'h1C32;
  localparam logic [15:0] IDX_ENCODER_INPUT = 16'h6000;

  // Subindices of the output synchronisation parameters.
  localparam logic [7:0] SUB_COUNT     = 8'h00;
  localparam logic [7:0] SUB_FIRST     = 8'h01;
  localparam logic [7:0] SUB_SYNC_MODE = 8'h01;
  localparam logic [7:0] SUB_CYCLE     = 8'h02;
  localparam logic [7:0] SUB_SHIFT     = 8'h03;
  localparam logic [7:0] SUB_SUPPORTED = 8'h04;

  // Mapping entries: object index, entry subindex, bit length.
  localparam logic [31:0] FREQ_ENTRY  = {IDX_ENCODER_INPUT, 8'h13, 8'h20};
  localparam logic [31:0] STAMP_ENTRY = {IDX_ENCODER_INPUT, 8'h16, 8'h40};
  localparam logic [31:0] SHORT_ENTRY = {IDX_ENCODER_INPUT, 8'h16, 8'h20};
  localparam logic [7:0]  MAP_COUNT   = 8'h01;

  // Sync-manager channel types.
  localparam logic [7:0] CHANNEL_COUNT  = 8'h04;
  localparam logic [7:0] CH_MBOX_WRITE  = 8'h01;
  localparam logic [7:0] CH_MBOX_READ   = 8'h02;
  localparam logic [7:0] CH_PD_OUTPUT   = 8'h03;
  localparam logic [7:0] CH_PD_INPUT    = 8'h04;

  // Assignment reset values and capacities.
  localparam logic [7:0]  OUT_ASSIGN_RESET = 8'h01;
  localparam logic [7:0]  OUT_ASSIGN_MAX   = 8'h01;
  localparam logic [15:0] OUT_SLOT1_RESET  = 16'h1600;
  localparam logic [7:0]  IN_ASSIGN_RESET  = 8'h02;
  localparam logic [7:0]  IN_ASSIGN_MAX    = 8'h03;
  localparam logic [15:0] IN_SLOT1_RESET   = 16'h1A00;
  localparam logic [15:0] IN_SLOT2_RESET   = 16'h1A02;
  localparam logic [15:0] IN_SLOT3_RESET   = 16'h0000;

  // Output synchronisation parameters.
  localparam logic [7:0]  SYNC_PARAM_COUNT = 8'h20;
  localparam logic [15:0] SYNC_MODE_RESET  = 16'h0001;
  localparam logic [15:0] SYNC_FREE_RUN    = 16'h0000;
  localparam logic [15:0] SYNC_SM2         = 16'h0001;
  localparam logic [15:0] SYNC_DC0         = 16'h0002;
  localparam logic [15:0] SYNC_DC1         = 16'h0003;
  localparam logic [31:0] CYCLE_NS_RESET   = 32'h000F4240;
  localparam logic [31:0] SHIFT_NS_RESET   = 32'h00000000;
  localparam logic [15:0] SUPPORTED_SYNCS  = 16'hC807;
  localparam int          SUP_FREE_RUN_BIT = 0;
  localparam int          SUP_SM2_BIT      = 1;
  localparam int          SUP_DC_LSB       = 2;
  localparam int          SUP_DYNAMIC_BIT  = 14;

  // Local clock period used to advance the free-run timer.
  localparam logic [31:0] CLK_PERIOD_NS = 32'h0000000A;

  // Access answer codes.
  localparam logic [1:0] ERR_NONE      = 2'h0;
  localparam logic [1:0] ERR_READ_ONLY = 2'h1;
  localparam logic [1:0] ERR_NO_OBJECT = 2'h2;
  localparam logic [1:0] ERR_RANGE     = 2'h3;

endpackage : od_slice_pkg

// [od_const_rom.sv]
`timescale 1ns/1ps
// Read-only entries of the slice; every hit here is read-only by nature.
module od_const_rom (
  input  wire logic [15:0] index,
  input  wire logic [7:0]  sub,
  output logic             hit,
  output logic [31:0]      data
);

  always_comb
  begin
    hit  = 1'b1;
    data = 32'h00000000;
    unique case (index)
      od_slice_pkg::IDX_FREQ_MAP, od_slice_pkg::IDX_STAMP_MAP, od_slice_pkg::IDX_SHORT_MAP:
      begin
        if (sub == od_slice_pkg::SUB_COUNT)
          data = {24'h000000, od_slice_pkg::MAP_COUNT};
        else if (sub == od_slice_pkg::SUB_FIRST && index == od_slice_pkg::IDX_FREQ_MAP)
          data = od_slice_pkg::FREQ_ENTRY;
        else if (sub == od_slice_pkg::SUB_FIRST && index == od_slice_pkg::IDX_STAMP_MAP)
          data = od_slice_pkg::STAMP_ENTRY;
        else if (sub == od_slice_pkg::SUB_FIRST)
          data = od_slice_pkg::SHORT_ENTRY;
        else
          hit = 1'b0;
      end
      od_slice_pkg::IDX_CHANNEL_TYPE:
      begin
        unique case (sub)
          od_slice_pkg::SUB_COUNT: data = {24'h000000, od_slice_pkg::CHANNEL_COUNT};
          8'h01:                   data = {24'h000000, od_slice_pkg::CH_MBOX_WRITE};
          8'h02:                   data = {24'h000000, od_slice_pkg::CH_MBOX_READ};
          8'h03:                   data = {24'h000000, od_slice_pkg::CH_PD_OUTPUT};
          8'h04:                   data = {24'h000000, od_slice_pkg::CH_PD_INPUT};
          default:                 hit  = 1'b0;
        endcase
      end
      od_slice_pkg::IDX_OUT_SYNC:
      begin
        unique case (sub)
          od_slice_pkg::SUB_COUNT:     data = {24'h000000, od_slice_pkg::SYNC_PARAM_COUNT};
          od_slice_pkg::SUB_SHIFT:     data = od_slice_pkg::SHIFT_NS_RESET;
          od_slice_pkg::SUB_SUPPORTED: data = {16'h0000, od_slice_pkg::SUPPORTED_SYNCS};
          default:                     hit  = 1'b0;
        endcase
      end
      default:
        hit = 1'b0;
    endcase
  end

endmodule : od_const_rom

// [od_slice.sv]
`timescale 1ns/1ps
// What this block does
// - Frequency mapping holds one 32-bit frequency entry.
// - Timestamp mapping holds one 64-bit timestamp entry.
// - Compact timestamp mapping holds one 32-bit entry.
// - Four channels typed mailbox write/read, output, input.
// - Output assignment resets to one slot, 0x1600.
// - Input assignment resets to 0x1A00, 0x1A02, zero; writable.
// - Sync mode selects free run, SM2, SYNC0, SYNC1.
// - Cycle time in ns, resets to one million.
// - Shift time is read-only, zero after reset.
// - Supported modes word reads 0xC807.
// - Supported bit 14 flags dynamic cycle times.
module od_slice (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_index,
  input  wire logic [7:0]  req_sub,
  input  wire logic [31:0] req_wdata,
  input  wire logic        sm2_event,
  input  wire logic        sync0_event,
  input  wire logic        sync1_event,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_error,
  output logic [1:0]       rsp_code,
  output logic             output_update,
  output logic [15:0]      sync_mode
);

  logic        rom_hit;
  logic [31:0] rom_data;
  logic [7:0]  out_count;
  logic [15:0] out_slot1;
  logic [7:0]  in_count;
  logic [15:0] in_slot [3];
  logic [31:0] cycle_ns;
  logic [31:0] timer_ns;
  logic        timer_hit;
  logic [32:0] timer_sum;
  logic        next_hit;
  logic        next_writable;
  logic        next_in_range;
  logic [31:0] next_rdata;
  logic        do_write;

  od_const_rom const_rom (
    .index (req_index),
    .sub   (req_sub),
    .hit   (rom_hit),
    .data  (rom_data)
  );

  // Decode of the writable entries and of the read value.
  always_comb
  begin
    next_hit      = 1'b1;
    next_writable = 1'b1;
    next_in_range = 1'b1;
    next_rdata    = 32'h00000000;
    if (rom_hit)
    begin
      next_writable = 1'b0;
      next_rdata    = rom_data;
    end
    else if (req_index == od_slice_pkg::IDX_OUT_ASSIGN && req_sub == od_slice_pkg::SUB_COUNT)
    begin
      next_rdata    = {24'h000000, out_count};
      next_in_range = req_wdata[7:0] <= od_slice_pkg::OUT_ASSIGN_MAX;
    end
    else if (req_index == od_slice_pkg::IDX_OUT_ASSIGN && req_sub == od_slice_pkg::SUB_FIRST)
      next_rdata = {16'h0000, out_slot1};
    else if (req_index == od_slice_pkg::IDX_IN_ASSIGN && req_sub == od_slice_pkg::SUB_COUNT)
    begin
      next_rdata    = {24'h000000, in_count};
      next_in_range = req_wdata[7:0] <= od_slice_pkg::IN_ASSIGN_MAX;
    end
    else if (req_index == od_slice_pkg::IDX_IN_ASSIGN && req_sub >= 8'h01 && req_sub <= 8'h03)
      next_rdata = {16'h0000, in_slot[req_sub[1:0] - 2'h1]};
    else if (req_index == od_slice_pkg::IDX_OUT_SYNC && req_sub == od_slice_pkg::SUB_SYNC_MODE)
    begin
      next_rdata    = {16'h0000, sync_mode};
      // Codes above three have no meaning, so they are refused at the door.
      next_in_range = req_wdata[15:0] <= od_slice_pkg::SYNC_DC1;
    end
    else if (req_index == od_slice_pkg::IDX_OUT_SYNC && req_sub == od_slice_pkg::SUB_CYCLE)
      next_rdata = cycle_ns;
    else
    begin
      next_hit      = 1'b0;
      next_writable = 1'b0;
    end
  end

  assign do_write = req_valid && req_write && next_hit && next_writable && next_in_range;

  // Answer to every request, one cycle after it is taken.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h00000000;
      rsp_error <= 1'b0;
      rsp_code  <= od_slice_pkg::ERR_NONE;
    end
    else
    begin
      rsp_valid <= req_valid;
      if (req_valid)
      begin
        rsp_rdata <= req_write ? 32'h00000000 : next_rdata;
        if (!next_hit)
        begin
          rsp_error <= 1'b1;
          rsp_code  <= od_slice_pkg::ERR_NO_OBJECT;
        end
        else if (req_write && !next_writable)
        begin
          rsp_error <= 1'b1;
          rsp_code  <= od_slice_pkg::ERR_READ_ONLY;
        end
        else if (req_write && !next_in_range)
        begin
          rsp_error <= 1'b1;
          rsp_code  <= od_slice_pkg::ERR_RANGE;
        end
        else
        begin
          rsp_error <= 1'b0;
          rsp_code  <= od_slice_pkg::ERR_NONE;
        end
      end
    end
  end

  // Output process-data assignment.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_count <= od_slice_pkg::OUT_ASSIGN_RESET;
      out_slot1 <= od_slice_pkg::OUT_SLOT1_RESET;
    end
    else if (do_write && req_index == od_slice_pkg::IDX_OUT_ASSIGN)
    begin
      if (req_sub == od_slice_pkg::SUB_COUNT)
        out_count <= req_wdata[7:0];
      else
        out_slot1 <= req_wdata[15:0];
    end
  end

  // Input process-data assignment count.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      in_count <= od_slice_pkg::IN_ASSIGN_RESET;
    else if (do_write && req_index == od_slice_pkg::IDX_IN_ASSIGN
             && req_sub == od_slice_pkg::SUB_COUNT)
      in_count <= req_wdata[7:0];
  end

  // Input assignment slots, one register per slot.
  for (genvar s = 0; s < 3; s++)
  begin : g_in_slot
    localparam logic [15:0] SLOT_RESET = (s == 0) ? od_slice_pkg::IN_SLOT1_RESET :
                                         (s == 1) ? od_slice_pkg::IN_SLOT2_RESET :
                                                    od_slice_pkg::IN_SLOT3_RESET;
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
        in_slot[s] <= SLOT_RESET;
      else if (do_write && req_index == od_slice_pkg::IDX_IN_ASSIGN
               && req_sub == 8'(s + 1))
        in_slot[s] <= req_wdata[15:0];
    end
  end

  // Output synchronisation mode and cycle time.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync_mode <= od_slice_pkg::SYNC_MODE_RESET;
      cycle_ns  <= od_slice_pkg::CYCLE_NS_RESET;
    end
    else if (do_write && req_index == od_slice_pkg::IDX_OUT_SYNC)
    begin
      if (req_sub == od_slice_pkg::SUB_SYNC_MODE)
        sync_mode <= req_wdata[15:0];
      else
        cycle_ns <= req_wdata;
    end
  end

  // Free-run local timer: accumulates nanoseconds and wraps at the cycle time.
  // Counting in ns rather than cycles avoids a divider; the remainder is dropped on wrap,
  // so a cycle time that is not a multiple of the clock period rounds up to whole cycles.
  assign timer_sum = {1'b0, timer_ns} + {1'b0, od_slice_pkg::CLK_PERIOD_NS};
  assign timer_hit = timer_sum >= {1'b0, cycle_ns};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      timer_ns <= 32'h00000000;
    else if (sync_mode != od_slice_pkg::SYNC_FREE_RUN || timer_hit)
      timer_ns <= 32'h00000000;
    else
      timer_ns <= timer_sum[31:0];
  end

  // Output refresh pulse chosen by the sync mode.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      output_update <= 1'b0;
    else
    begin
      unique case (sync_mode)
        od_slice_pkg::SYNC_FREE_RUN: output_update <= timer_hit;
        od_slice_pkg::SYNC_SM2:      output_update <= sm2_event;
        od_slice_pkg::SYNC_DC0:      output_update <= sync0_event;
        od_slice_pkg::SYNC_DC1:      output_update <= sync1_event;
        default:                     output_update <= 1'b0;
      endcase
    end
  end

  AST_FREQ_MAP: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_FREQ_MAP && req_sub == 8'h01
    |=> rsp_valid && !rsp_error && rsp_rdata == 32'h60001320)
    else $error("frequency mapping entry wrong");

  AST_STAMP_MAP: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_STAMP_MAP && req_sub == 8'h01
    |=> rsp_rdata == 32'h60001640 && !rsp_error)
    else $error("timestamp mapping entry wrong");

  AST_SHORT_MAP: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_SHORT_MAP && req_sub == 8'h01
    |=> rsp_rdata == 32'h60001620 && !rsp_error)
    else $error("compact timestamp mapping entry wrong");

  AST_CHANNEL_TYPE: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_CHANNEL_TYPE
    && req_sub >= 8'h01 && req_sub <= 8'h04
    |=> rsp_rdata == {24'h000000, $past(req_sub)})
    else $error("channel type wrong");

  AST_OUT_ASSIGN_RESET: assert property (@(posedge clk_sys)
    $fell(rst) |-> out_count == 8'h01 && out_slot1 == 16'h1600)
    else $error("output assignment reset wrong");

  AST_IN_ASSIGN_RESET: assert property (@(posedge clk_sys)
    $fell(rst) |-> in_count == 8'h02 && in_slot[0] == 16'h1A00
    && in_slot[1] == 16'h1A02 && in_slot[2] == 16'h0000)
    else $error("input assignment reset wrong");

  AST_SYNC0_FOLLOW: assert property (@(posedge clk_sys) disable iff (rst)
    sync_mode == 16'h0002 && $stable(sync_mode) |=> output_update == $past(sync0_event))
    else $error("sync0 mode does not follow sync0 event");

  AST_FREE_RUN_GATE: assert property (@(posedge clk_sys) disable iff (rst)
    sync_mode == 16'h0000 && !timer_hit |=> !output_update)
    else $error("free run update without timer expiry");

  AST_SHIFT_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_OUT_SYNC && req_sub == 8'h03
    |=> rsp_rdata == 32'h00000000 && !rsp_error)
    else $error("shift time not zero");

  AST_SUPPORTED: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_OUT_SYNC && req_sub == 8'h04
    |=> rsp_rdata == 32'h0000C807 && rsp_rdata[3:2] == 2'b01)
    else $error("supported modes word wrong");

  AST_MAP_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_sub == 8'h00 && (req_index == od_slice_pkg::IDX_FREQ_MAP
    || req_index == od_slice_pkg::IDX_STAMP_MAP || req_index == od_slice_pkg::IDX_SHORT_MAP)
    |=> rsp_rdata == 32'h00000001)
    else $error("mapping count not one");

  AST_RO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req_write && rom_hit
    |=> rsp_error && rsp_code == 2'h1 && $stable(sync_mode) && $stable(cycle_ns))
    else $error("read-only write not refused");

  AST_DYNAMIC_BIT: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && !req_write && req_index == od_slice_pkg::IDX_OUT_SYNC && req_sub == 8'h04
    |=> rsp_rdata[14] == 1'b1)
    else $error("dynamic times bit missing");

endmodule : od_slice

// [master_model.sv]
`timescale 1ns/1ps
// Stands in for the fieldbus master: mailbox object accesses and sync event pulses.
module master_model (
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  input  wire logic        rsp_error,
  input  wire logic [1:0]  rsp_code,
  output logic             req_valid,
  output logic             req_write,
  output logic [15:0]      req_index,
  output logic [7:0]       req_sub,
  output logic [31:0]      req_wdata,
  output logic             sm2_event,
  output logic             sync0_event,
  output logic             sync1_event
);
  initial
  begin
    req_valid   = 1'b0;
    req_write   = 1'b0;
    req_index   = 16'h0000;
    req_sub     = 8'h00;
    req_wdata   = 32'h00000000;
    sm2_event   = 1'b0;
    sync0_event = 1'b0;
    sync1_event = 1'b0;
  end

  // Rewrites of assignment slots, sync mode and cycle time all go through here.
  task automatic access(
    input  logic        write,
    input  logic [15:0] index,
    input  logic [7:0]  sub,
    input  logic [31:0] wdata,
    output logic        seen_valid,
    output logic [31:0] rdata,
    output logic        error,
    output logic [1:0]  code
  );
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= write;
    req_index <= index;
    req_sub   <= sub;
    req_wdata <= wdata;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // Released lines carry the inverse so a stale value can never pass for a live one.
    req_write <= ~write;
    req_index <= ~index;
    req_sub   <= ~sub;
    req_wdata <= ~wdata;
    #1;
    seen_valid = rsp_valid;
    rdata      = rsp_rdata;
    error      = rsp_error;
    code       = rsp_code;
  endtask : access

  task automatic pulse(input logic [1:0] source);
    @(posedge clk_sys);
    sm2_event   <= (source == 2'h1);
    sync0_event <= (source == 2'h2);
    sync1_event <= (source == 2'h3);
    @(posedge clk_sys);
    sm2_event   <= 1'b0;
    sync0_event <= 1'b0;
    sync1_event <= 1'b0;
    #1;
  endtask : pulse
endmodule : master_model

// [encoder_pdo_sync_objects_bench.sv]
`timescale 1ns/1ps
module encoder_pdo_sync_objects_bench;
  typedef struct packed {
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  code;
  } row_t;

  logic        clk_sys;
  logic        rst;
  logic        req_valid;
  logic        req_write;
  logic [15:0] req_index;
  logic [7:0]  req_sub;
  logic [31:0] req_wdata;
  logic        sm2_event;
  logic        sync0_event;
  logic        sync1_event;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        rsp_error;
  logic [1:0]  rsp_code;
  logic        output_update;
  logic [15:0] sync_mode;
  row_t        rows [0:41];
  int          failures;
  int          samples_checked;
  int          cycles;
  int          gap;
  int          n;

  od_slice i_od_slice (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .req_valid     (req_valid),
    .req_write     (req_write),
    .req_index     (req_index),
    .req_sub       (req_sub),
    .req_wdata     (req_wdata),
    .sm2_event     (sm2_event),
    .sync0_event   (sync0_event),
    .sync1_event   (sync1_event),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata),
    .rsp_error     (rsp_error),
    .rsp_code      (rsp_code),
    .output_update (output_update),
    .sync_mode     (sync_mode)
  );

  master_model i_master_model (
    .clk_sys     (clk_sys),
    .rsp_valid   (rsp_valid),
    .rsp_rdata   (rsp_rdata),
    .rsp_error   (rsp_error),
    .rsp_code    (rsp_code),
    .req_valid   (req_valid),
    .req_write   (req_write),
    .req_index   (req_index),
    .req_sub     (req_sub),
    .req_wdata   (req_wdata),
    .sm2_event   (sm2_event),
    .sync0_event (sync0_event),
    .sync1_event (sync1_event)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic run_row(input int i);
    logic        v;
    logic [31:0] d;
    logic        e;
    logic [1:0]  c;
    i_master_model.access(rows[i].write, rows[i].index, rows[i].sub, rows[i].wdata, v, d, e, c);
    check("rsp_valid", 32'h1, {31'h0, v});
    check("rsp_code", {30'h0, rows[i].code}, {30'h0, c});
    check("rsp_error", {31'h0, rows[i].code != 2'h0}, {31'h0, e});
    if (rows[i].code == 2'h0)
      check("rsp_rdata", rows[i].write ? 32'h0 : rows[i].rdata, d);
  endtask : run_row

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    logic        v;
    logic [31:0] d;
    logic        e;
    logic [1:0]  c;
    clk_sys = 1'b0;
    rst = 1'b1;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    rows = '{
      '{1'b0, 16'h1A03, 8'h00, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1A03, 8'h01, 32'h0, 32'h60001320, 2'h0},
      '{1'b0, 16'h1A04, 8'h00, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1A04, 8'h01, 32'h0, 32'h60001640, 2'h0},
      '{1'b0, 16'h1A05, 8'h00, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1A05, 8'h01, 32'h0, 32'h60001620, 2'h0},
      '{1'b0, 16'h1C00, 8'h00, 32'h0, 32'h4, 2'h0},
      '{1'b0, 16'h1C00, 8'h01, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1C00, 8'h02, 32'h0, 32'h2, 2'h0},
      '{1'b0, 16'h1C00, 8'h03, 32'h0, 32'h3, 2'h0},
      '{1'b0, 16'h1C00, 8'h04, 32'h0, 32'h4, 2'h0},
      '{1'b0, 16'h1C12, 8'h00, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1C12, 8'h01, 32'h0, 32'h1600, 2'h0},
      '{1'b0, 16'h1C13, 8'h00, 32'h0, 32'h2, 2'h0},
      '{1'b0, 16'h1C13, 8'h01, 32'h0, 32'h1A00, 2'h0},
      '{1'b0, 16'h1C13, 8'h02, 32'h0, 32'h1A02, 2'h0},
      '{1'b0, 16'h1C13, 8'h03, 32'h0, 32'h0, 2'h0},
      '{1'b0, 16'h1C32, 8'h00, 32'h0, 32'h20, 2'h0},
      '{1'b0, 16'h1C32, 8'h01, 32'h0, 32'h1, 2'h0},
      '{1'b0, 16'h1C32, 8'h02, 32'h0, 32'hF4240, 2'h0},
      '{1'b0, 16'h1C32, 8'h03, 32'h0, 32'h0, 2'h0},
      '{1'b0, 16'h1C32, 8'h04, 32'h0, 32'hC807, 2'h0},
      '{1'b1, 16'h1A03, 8'h00, 32'h5, 32'h0, 2'h1},
      '{1'b0, 16'h1A03, 8'h00, 32'h0, 32'h1, 2'h0},
      '{1'b1, 16'h1A04, 8'h01, 32'h0, 32'h0, 2'h1},
      '{1'b0, 16'h1A04, 8'h01, 32'h0, 32'h60001640, 2'h0},
      '{1'b1, 16'h1C32, 8'h03, 32'h55, 32'h0, 2'h1},
      '{1'b0, 16'h1C32, 8'h03, 32'h0, 32'h0, 2'h0},
      '{1'b1, 16'h1C32, 8'h04, 32'h0, 32'h0, 2'h1},
      '{1'b0, 16'h1C32, 8'h04, 32'h0, 32'hC807, 2'h0},
      '{1'b1, 16'h1C13, 8'h01, 32'h1A03, 32'h0, 2'h0},
      '{1'b0, 16'h1C13, 8'h01, 32'h0, 32'h1A03, 2'h0},
      '{1'b1, 16'h1C13, 8'h00, 32'h4, 32'h0, 2'h3},
      '{1'b0, 16'h1C13, 8'h00, 32'h0, 32'h2, 2'h0},
      '{1'b1, 16'h1C32, 8'h01, 32'h4, 32'h0, 2'h3},
      '{1'b0, 16'h1C32, 8'h01, 32'h0, 32'h1, 2'h0},
      '{1'b1, 16'h1C32, 8'h02, 32'h2710, 32'h0, 2'h0},
      '{1'b0, 16'h1C32, 8'h02, 32'h0, 32'h2710, 2'h0},
      '{1'b0, 16'h1C32, 8'h05, 32'h0, 32'h0, 2'h2},
      '{1'b0, 16'h1234, 8'h00, 32'h0, 32'h0, 2'h2},
      '{1'b1, 16'h1C12, 8'h00, 32'h2, 32'h0, 2'h3},
      '{1'b1, 16'h1C00, 8'h01, 32'h7, 32'h0, 2'h1}
    };
    #1;
    check("sync_mode", 32'h1, {16'h0, sync_mode});
    check("rsp_valid", 32'h0, {31'h0, rsp_valid});
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 42; i++)
      run_row(i);
    for (int m = 1; m < 4; m++)
    begin
      i_master_model.access(1'b1, 16'h1C32, 8'h01, 32'(m), v, d, e, c);
      check("sync_mode", 32'(m), {16'h0, sync_mode});
      for (int s = 1; s < 4; s++)
      begin
        i_master_model.pulse(2'(s));
        check("output_update", 32'(s == m), {31'h0, output_update});
      end
    end
    // A 100 ns local timer at a 10 ns clock should refresh every 10 cycles.
    i_master_model.access(1'b1, 16'h1C32, 8'h02, 32'h64, v, d, e, c);
    i_master_model.access(1'b1, 16'h1C32, 8'h01, 32'h0, v, d, e, c);
    gap = 0;
    n = 0;
    while (n < 2 && gap < 50)
    begin
      @(posedge clk_sys);
      #1;
      gap++;
      if (output_update === 1'b1)
      begin
        n++;
        if (n == 1)
          gap = 0;
      end
    end
    check("free_run_period", 32'hA, 32'(gap));
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check("sync_mode", 32'h1, {16'h0, sync_mode});
    run_row(14);
    run_row(18);
    run_row(19);
    close_out();
  end
endmodule : encoder_pdo_sync_objects_bench
